// ==== tbr_pkg.sv ====
// Constants, types and register map of the timer and burst-read configuration block.
// Assumes a 100 MHz core clock and a one-cycle tick pulse from the 10 Hz low-speed clock.
package tbr_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] TBR_TIMER_CONTROL_ADDR = 8'h4A;
    localparam logic [7:0] TBR_BURST_COUNT_ADDR = 8'h4B;
    localparam logic [7:0] TBR_TIMER_CONTROL_RST = 8'h00;
    localparam logic [7:0] TBR_BURST_COUNT_RST = 8'h06;
    localparam logic [7:0] TBR_READ_NONE = 8'h00;

    // timer_control fields
    localparam int TBR_TILT_LSB = 0;
    localparam int TBR_PERIOD_LSB = 4;
    localparam int TBR_LATCH_EN_BIT = 7;

    // ------------------------------------------------------------
    // timing, in milliseconds and in ticks of the low-speed clock
    // ------------------------------------------------------------
    localparam int TBR_TICK_MS = 100;
    localparam int TBR_TILT_BASE_MS = 1600;
    localparam int TBR_TILT_STEP_MS = 200;
    localparam int TBR_LATCH_BASE_MS = 200;
    localparam logic [2:0] TBR_PERIOD_MAX_CODE = 3'h5;
    localparam int TBR_TILT_BASE_TICKS = TBR_TILT_BASE_MS / TBR_TICK_MS;
    localparam int TBR_TILT_STEP_TICKS = TBR_TILT_STEP_MS / TBR_TICK_MS;
    localparam int TBR_LATCH_BASE_TICKS = TBR_LATCH_BASE_MS / TBR_TICK_MS;
    localparam int TBR_TICK_W = 7;

    // ------------------------------------------------------------
    // sample layout
    // ------------------------------------------------------------
    localparam int TBR_DATA_BYTES = 6;
    localparam int TBR_SAMPLE_W = 8 * TBR_DATA_BYTES;
    localparam int TBR_SHIFT_W = TBR_SAMPLE_W + 16;
    localparam logic [3:0] TBR_LEN_DATA = 4'h6;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tbr_reg_req_t;

    typedef enum logic [2:0] {
        TBR_IDLE = 3'b001,
        TBR_LOAD = 3'b010,
        TBR_SEND = 3'b100
    } tbr_state_t;

endpackage

// ==== tbr_top.sv ====
// Timer control, burst sample count, tilt-35 timer, temporary pin latch and burst serialiser.
// Assumes the host port logic presents decoded register accesses and drains the byte stream.
`timescale 1ns/1ns
`default_nettype none

module tbr_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, rp_r;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic full_r, empty_r;
    wire push = in_valid && !full_r;
    wire pop = out_ready && !empty_r;
    wire [AW-1:0] wp_inc = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    wire [AW-1:0] rp_inc = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;

    assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    assign in_ready = !full_r;
    assign out_valid = !empty_r;
    assign out_data = mem[rp_r];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            full_r <= 1'b0;
            empty_r <= 1'b1;
        end else begin
            wp_r <= push ? wp_inc : wp_r;
            rp_r <= pop ? rp_inc : rp_r;
            cnt_r <= cnt_nxt;
            full_r <= (cnt_nxt == CW'(DEPTH));
            empty_r <= (cnt_nxt == '0);
        end
    end
endmodule // tbr_fifo

module tbr_top import tbr_pkg::*; #(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register access from the host port
    input wire tbr_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // low-speed clock tick and detector inputs
    input wire logic tick_10hz,
    input wire logic tilt35_cond,
    input wire logic int_event,
    // tilt-35 and interrupt test pin results
    output logic tilt35_valid,
    output logic test_int_pin,
    // device configuration from other registers
    input wire logic fifo_burst_enable,
    input wire logic [1:0] status_byte_count,
    input wire logic [7:0] status_13,
    input wire logic [7:0] status_14,
    // samples into the buffer
    input wire logic smp_valid,
    input wire logic [TBR_SAMPLE_W-1:0] smp_data,
    output logic smp_ready,
    // burst read request and byte stream
    input wire logic burst_req,
    output logic burst_busy,
    output logic burst_done,
    output logic byte_valid,
    output logic [7:0] byte_data,
    input wire logic byte_ready
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] timer_control_r;
    logic [7:0] burst_sample_count_r;
    logic [7:0] reg_rdata_nxt;
    wire wr_timer = reg_req.wr && (reg_req.addr == TBR_TIMER_CONTROL_ADDR);
    wire wr_count = reg_req.wr && (reg_req.addr == TBR_BURST_COUNT_ADDR);
    wire rd_count = reg_req.rd && (reg_req.addr == TBR_BURST_COUNT_ADDR);
    // timer_control is write-only, so it reads back as zero
    assign reg_rdata_nxt = rd_count ? burst_sample_count_r : TBR_READ_NONE;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timer_control_r <= TBR_TIMER_CONTROL_RST;
            burst_sample_count_r <= TBR_BURST_COUNT_RST;
            reg_rdata <= TBR_READ_NONE;
        end else begin
            timer_control_r <= wr_timer ? reg_req.wdata : timer_control_r;
            burst_sample_count_r <= wr_count ? reg_req.wdata : burst_sample_count_r;
            reg_rdata <= reg_rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // tilt-35 duration timer
    // ------------------------------------------------------------
    wire [2:0] tilt_code = timer_control_r[TBR_TILT_LSB +: 3];
    wire [2:0] period_code = timer_control_r[TBR_PERIOD_LSB +: 3];
    wire latch_feature_enable = timer_control_r[TBR_LATCH_EN_BIT];
    wire [TBR_TICK_W-1:0] tilt_ticks = TBR_TICK_W'(TBR_TILT_BASE_TICKS)
        + TBR_TICK_W'(tilt_code) * TBR_TICK_W'(TBR_TILT_STEP_TICKS);
    logic [TBR_TICK_W-1:0] tilt_cnt_r;
    wire tilt_reached = (tilt_cnt_r >= tilt_ticks);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tilt_cnt_r <= '0;
            tilt35_valid <= 1'b0;
        end else begin
            // counts only on low-speed ticks, restarts when the angle goes away
            tilt_cnt_r <= !tilt35_cond ? '0 : (tick_10hz && !tilt_reached) ? tilt_cnt_r + 1'b1 : tilt_cnt_r;
            tilt35_valid <= tilt35_cond && tilt_reached;
        end
    end

    // ------------------------------------------------------------
    // temporary latch on the interrupt test pin
    // ------------------------------------------------------------
    // reserved period codes are clamped to the longest period
    wire [2:0] period_eff = (period_code > TBR_PERIOD_MAX_CODE) ? TBR_PERIOD_MAX_CODE : period_code;
    wire [TBR_TICK_W-1:0] latch_ticks = TBR_TICK_W'(TBR_LATCH_BASE_TICKS) << period_eff;
    logic [TBR_TICK_W-1:0] latch_cnt_r;
    logic latched_r;
    wire latch_expire = latched_r && tick_10hz && (latch_cnt_r + 1'b1 >= latch_ticks);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            latched_r <= 1'b0;
            latch_cnt_r <= '0;
            test_int_pin <= 1'b0;
        end else begin
            // held for the period, then released and ready for the next event
            latched_r <= latch_feature_enable && (latched_r ? !latch_expire : int_event);
            latch_cnt_r <= (!latched_r || latch_expire) ? '0 : latch_cnt_r + TBR_TICK_W'(tick_10hz);
            test_int_pin <= latch_feature_enable ? (latched_r ? !latch_expire : int_event) : int_event;
        end
    end

    // ------------------------------------------------------------
    // sample buffer
    // ------------------------------------------------------------
    logic fifo_valid;
    logic [TBR_SAMPLE_W-1:0] fifo_data;
    logic fifo_in_ready;
    tbr_state_t state_r, state_nxt;
    wire fifo_pop = (state_r == TBR_LOAD) && fifo_valid;

    tbr_fifo #(.WIDTH(TBR_SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(smp_valid),
        .in_data(smp_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            smp_ready <= 1'b0;
        end else begin
            smp_ready <= fifo_in_ready;
        end
    end

    // ------------------------------------------------------------
    // burst serialiser
    // ------------------------------------------------------------
    logic [7:0] samples_left_r, samples_left_nxt;
    logic [3:0] bytes_left_r, bytes_left_nxt;
    logic [TBR_SHIFT_W-1:0] shift_r, shift_nxt;
    logic [7:0] byte_data_nxt;
    logic byte_valid_nxt, done_nxt;
    // the count is a number of samples; a sample is 6, 7 or 8 bytes
    wire [3:0] status_len = (status_byte_count > 2'h2) ? 4'h2 : {2'h0, status_byte_count};
    wire [3:0] sample_len = TBR_LEN_DATA + status_len;
    // with burst mode off one sample is served and the count ignored
    wire [7:0] burst_len = fifo_burst_enable ? burst_sample_count_r : 8'h01;
    wire handshake = byte_valid && byte_ready;
    wire last_byte = (bytes_left_r == 4'h1);
    wire last_sample = (samples_left_r == 8'h01);

    always_comb begin
        state_nxt = state_r;
        samples_left_nxt = samples_left_r;
        bytes_left_nxt = bytes_left_r;
        shift_nxt = shift_r;
        byte_data_nxt = byte_data;
        byte_valid_nxt = byte_valid;
        done_nxt = 1'b0;
        case (state_r)
            TBR_IDLE: begin
                if (burst_req && burst_len == 8'h00) begin
                    done_nxt = 1'b1;
                end else if (burst_req) begin
                    samples_left_nxt = burst_len;
                    state_nxt = TBR_LOAD;
                end
            end
            TBR_LOAD: begin
                if (fifo_valid) begin
                    byte_data_nxt = fifo_data[7:0];
                    shift_nxt = {status_14, status_13, fifo_data} >> 8;
                    bytes_left_nxt = sample_len;
                    byte_valid_nxt = 1'b1;
                    state_nxt = TBR_SEND;
                end
            end
            TBR_SEND: begin
                if (handshake && !last_byte) begin
                    byte_data_nxt = shift_r[7:0];
                    shift_nxt = shift_r >> 8;
                    bytes_left_nxt = bytes_left_r - 1'b1;
                end else if (handshake) begin
                    byte_valid_nxt = 1'b0;
                    samples_left_nxt = samples_left_r - 1'b1;
                    done_nxt = last_sample;
                    state_nxt = last_sample ? TBR_IDLE : TBR_LOAD;
                end
            end
            default: begin
                byte_valid_nxt = 1'b0;
                state_nxt = TBR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= TBR_IDLE;
            samples_left_r <= '0;
            bytes_left_r <= '0;
            shift_r <= '0;
            byte_data <= '0;
            byte_valid <= 1'b0;
            burst_done <= 1'b0;
            burst_busy <= 1'b0;
        end else begin
            state_r <= state_nxt;
            samples_left_r <= samples_left_nxt;
            bytes_left_r <= bytes_left_nxt;
            shift_r <= shift_nxt;
            byte_data <= byte_data_nxt;
            byte_valid <= byte_valid_nxt;
            burst_done <= done_nxt;
            burst_busy <= (state_nxt != TBR_IDLE);
        end
    end
endmodule // tbr_top

`default_nettype wire

// ==== tbr_monitor.sv ====
// Concurrent checks of tbr_top, bound from the testbench top file.
// Assumes every register write reaches the block as reg_req.
`timescale 1ns/1ns
`default_nettype none
module tbr_monitor import tbr_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register access
    input wire tbr_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // timers
    input wire logic tick_10hz,
    input wire logic tilt35_cond,
    input wire logic tilt35_valid,
    input wire logic test_int_pin,
    input wire logic int_event,
    // burst
    input wire logic fifo_burst_enable,
    input wire logic [1:0] status_byte_count,
    input wire logic burst_req,
    input wire logic burst_busy,
    input wire logic burst_done,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_ready
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // shadows of the programmed values, bodies are not visible
    logic [7:0] ctl_r, cnt_r, tk_r;
    logic [15:0] nb_r, exp_w;
    logic [3:0] slen;
    assign slen = 4'h6 + ((status_byte_count == 2'h3) ? 4'h2 : {2'h0, status_byte_count});
    assign exp_w = {8'h00, (fifo_burst_enable ? cnt_r : 8'h01)} * {12'h000, slen};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctl_r <= 8'h00;
            cnt_r <= 8'h06;
        end else if (reg_req.wr && reg_req.addr == 8'h4A) begin
            ctl_r <= reg_req.wdata;
        end else if (reg_req.wr && reg_req.addr == 8'h4B) begin
            cnt_r <= reg_req.wdata;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n || !tilt35_cond) tk_r <= 8'h00;
        else if (tick_10hz && tk_r != 8'hFF) tk_r <= tk_r + 8'h01;
    end
    always_ff @(posedge clock) begin
        if (!rst_n || (burst_req && !burst_busy)) nb_r <= 16'h0000;
        else if (byte_valid && byte_ready) nb_r <= nb_r + 16'h0001;
    end
    property p_reg_rd;
        reg_req.rd |=> reg_rdata == (($past(reg_req.addr) == 8'h4B) ? $past(cnt_r) : 8'h00);
    endproperty
    a_reg_rd: assert property (p_reg_rd) else $error("bad read data");
    property p_tilt_fall;
        !tilt35_cond |=> !tilt35_valid;
    endproperty
    a_tilt_fall: assert property (p_tilt_fall) else $error("tilt valid held");
    property p_tilt_ticks;
        $rose(tilt35_valid) |-> tk_r >= 8'h10 + {4'h0, ctl_r[2:0], 1'b0};
    endproperty
    a_tilt_ticks: assert property (p_tilt_ticks) else $error("tilt valid early");
    property p_pin_follow;
        !$past(ctl_r[7]) && !ctl_r[7] |-> test_int_pin == $past(int_event);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin not following");
    property p_pin_release;
        $fell(test_int_pin) && ctl_r[7] && $past(ctl_r[7]) |-> $past(tick_10hz);
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin released off tick");
    property p_byte_hold;
        byte_valid && !byte_ready |=> byte_valid && $stable(byte_data);
    endproperty
    a_byte_hold: assert property (p_byte_hold) else $error("byte dropped");
    property p_burst_len;
        burst_done |-> nb_r == exp_w;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst length");
    property p_done_idle;
        burst_done |-> !burst_busy && !byte_valid;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while busy");
endmodule // tbr_monitor
`default_nettype wire

// ==== tbr_host.sv ====
// Host controller model: starts bursts and drains the byte stream.
// Assumes one burst at a time; slow stalls every other cycle.
`timescale 1ns/1ns
`default_nettype none
module tbr_host (
    // clock and mode
    input wire logic clock,
    input wire logic slow,
    // burst port
    output logic burst_req,
    output logic byte_ready,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic burst_done
);
    logic [7:0] got[$];
    logic ph_r;
    initial begin
        burst_req = 1'b0;
        byte_ready = 1'b0;
        ph_r = 1'b0;
    end
    always @(posedge clock) begin
        ph_r <= ~ph_r;
        byte_ready <= slow ? ph_r : 1'b1;
        if (byte_valid && byte_ready) got.push_back(byte_data);
    end
    task automatic burst();
        got.delete();
        @(posedge clock) burst_req <= 1'b1;
        @(posedge clock) burst_req <= 1'b0;
        for (int i = 0; i < 3000; i++) begin
            #1;
            if (burst_done === 1'b1) break;
            @(posedge clock);
        end
    endtask
endmodule // tbr_host
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench of tbr_top with the host model on the byte stream.
// Assumes tbr_monitor and tbr_host are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench import tbr_pkg::*; ;
    logic clock, rst_n, tick_10hz, tilt35_cond, int_event, tilt35_valid, test_int_pin;
    logic fifo_burst_enable, smp_valid, smp_ready, burst_req, burst_busy, burst_done;
    logic byte_valid, byte_ready, slow;
    logic [1:0] status_byte_count;
    logic [7:0] reg_rdata, status_13, status_14, byte_data, d;
    logic [47:0] smp_data;
    tbr_reg_req_t reg_req;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    tbr_top uut (.clock(clock), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .tick_10hz(tick_10hz), .tilt35_cond(tilt35_cond), .int_event(int_event),
        .tilt35_valid(tilt35_valid), .test_int_pin(test_int_pin), .fifo_burst_enable(fifo_burst_enable),
        .status_byte_count(status_byte_count), .status_13(status_13), .status_14(status_14),
        .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready), .burst_req(burst_req),
        .burst_busy(burst_busy), .burst_done(burst_done), .byte_valid(byte_valid),
        .byte_data(byte_data), .byte_ready(byte_ready));
    tbr_host host (.clock(clock), .slow(slow), .burst_req(burst_req), .byte_ready(byte_ready),
        .byte_valid(byte_valid), .byte_data(byte_data), .burst_done(burst_done));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock) reg_req <= '{1'b1, 1'b0, a, v};
        @(posedge clock) reg_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock) reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clock) reg_req <= '0;
        #1 d = reg_rdata;
    endtask
    // each tick is a one-cycle pulse with idle cycles between
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock) tick_10hz <= 1'b1;
            @(posedge clock) tick_10hz <= 1'b0;
            repeat (2) @(posedge clock);
        end
        #1;
    endtask
    task automatic burst_chk(input logic en, input logic [7:0] cnt, input logic [1:0] st);
        int n;
        int len;
        n = en ? int'(cnt) : 1;
        len = 6 + ((st == 2'h3) ? 2 : int'(st));
        wr(8'h4B, cnt);
        @(posedge clock) begin
            fifo_burst_enable <= en;
            status_byte_count <= st;
        end
        for (int i = 0; i < n; i++) @(posedge clock) begin
            smp_valid <= 1'b1;
            smp_data <= 48'hA5A4A3A2A1A0 + 48'(i) * 48'h010101010101;
        end
        @(posedge clock) smp_valid <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        if (n == 8) `CHK(smp_ready, 1'b0)
        host.burst();
        `CHK(host.got.size(), n * len)
        for (int i = 0; i < n; i++)
            for (int j = 0; j < len; j++)
                `CHK(host.got[i * len + j], j < 6 ? 8'hA0 + 8'(i + j) : (j == 6 ? status_13 : status_14))
        $display("burst test done, %0d samples", n);
    endtask
    initial begin
        {rst_n, tick_10hz, tilt35_cond, int_event, fifo_burst_enable, smp_valid, slow} = '0;
        {status_byte_count, smp_data, reg_req} = '0;
        status_13 = 8'h3C;
        status_14 = 8'hC3;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(8'h4B); `CHK(d, 8'h06)
        rd(8'h4A); `CHK(d, 8'h00)
        rd(8'h4C); `CHK(d, 8'h00)
        wr(8'h4B, 8'hFF); rd(8'h4B); `CHK(d, 8'hFF)
        wr(8'h4C, 8'h11); rd(8'h4B); `CHK(d, 8'hFF)
        @(posedge clock) int_event <= 1'b1;
        @(posedge clock); #1; `CHK(test_int_pin, 1'b1)
        @(posedge clock) int_event <= 1'b0;
        @(posedge clock); #1; `CHK(test_int_pin, 1'b0)
        $display("register test done");
        for (int c = 0; c < 8; c++) begin
            wr(8'h4A, 8'(c));
            @(posedge clock) tilt35_cond <= 1'b1;
            ticks(15 + 2 * c); `CHK(tilt35_valid, 1'b0)
            ticks(1); `CHK(tilt35_valid, 1'b1)
            @(posedge clock) tilt35_cond <= 1'b0;
            repeat (2) @(posedge clock); #1; `CHK(tilt35_valid, 1'b0)
        end
        $display("tilt test done");
        for (int c = 0; c < 8; c++) begin
            wr(8'h4A, {1'b1, 3'(c), 4'h0});
            @(posedge clock) int_event <= 1'b1;
            @(posedge clock) int_event <= 1'b0;
            ticks((2 << (c > 5 ? 5 : c)) - 1); `CHK(test_int_pin, 1'b1)
            ticks(1); `CHK(test_int_pin, 1'b0)
        end
        $display("latch test done");
        burst_chk(1'b1, 8'h02, 2'h2);
        slow <= 1'b1;
        burst_chk(1'b1, 8'h08, 2'h1);
        burst_chk(1'b0, 8'h02, 2'h0);
        burst_chk(1'b1, 8'h00, 2'h3);
        wrap_up();
    end
endmodule // testbench
bind tbr_top tbr_monitor mon (.clock(clock), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .tick_10hz(tick_10hz), .tilt35_cond(tilt35_cond), .tilt35_valid(tilt35_valid),
    .test_int_pin(test_int_pin), .int_event(int_event), .fifo_burst_enable(fifo_burst_enable),
    .status_byte_count(status_byte_count), .burst_req(burst_req), .burst_busy(burst_busy),
    .burst_done(burst_done), .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready));
`default_nettype wire
